/* logic/crcca_top.sv */
// CRC unit: control register, result access, byte input and automatic flash CRC
// Function
// - Control bits 7:5 read zero, writes ignored
// - Select 0 uses 32-bit polynomial 04C11DB7
// - Select 1 uses 16-bit polynomial 1021
// - Writing init bit loads whole result
// - Init value select: zeros or all ones
// - Pointer picks result byte for data port
// - Pointer increments after each data access
// - 32-bit mode pointer maps bytes 0..3
// - 16-bit mode pointer bit 0 picks byte
// - Third fetched opcode after auto start invalid
// - Each input byte folds into result
// - 16-bit algorithm MSB-first, shift left
// - 32-bit algorithm reflected, shift right
// - Auto enable makes control write start flash CRC when idle with nonzero sector count
`timescale 1ns/1ps
`include "crcca_map.svh"
module crcca_top (
   input  wire logic               mclk,
   input  wire logic               rst,
   input  wire crcca_pkg::crcca_sfr_t sfr,
   output logic      [7:0]         sfr_rdata_ff,
   output logic                    flash_req_ff,
   output logic      [15:0]        flash_addr_ff,
   input  wire logic [7:0]         flash_rdata,
   input  wire logic               flash_ack,
   output logic                    cpu_hold_ff
);
   import crcca_pkg::*;

   crcca_ctrl_t  ctrl_ff;
   crcca_ctrl_t  nxt_ctrl;
   crcca_state_t state_ff;
   crcca_state_t nxt_state;
   logic [31:0]  result_ff;
   logic [31:0]  nxt_result;
   logic [31:0]  fold_out;
   logic [7:0]   flip_ff;
   logic         auto_en_ff;
   logic [5:0]   start_sec_ff;
   logic [5:0]   sec_cnt_ff;
   logic [15:0]  remain_ff;

   function automatic logic [1:0] byte_idx(input logic sel16, input logic [1:0] p);
      byte_idx = sel16 ? {1'b0, p[0]} : p;
   endfunction

   function automatic logic [7:0] pick_byte(input logic [31:0] r, input logic [1:0] i);
      pick_byte = r[8*i +: 8];
   endfunction

   wire wr_ctrl  = sfr.wr && (sfr.addr == `CRCCA_ADDR_CTRL);
   wire rd_ctrl  = sfr.rd && (sfr.addr == `CRCCA_ADDR_CTRL);
   wire wr_data  = sfr.wr && (sfr.addr == `CRCCA_ADDR_DATA);
   wire rd_data  = sfr.rd && (sfr.addr == `CRCCA_ADDR_DATA);
   wire wr_in    = sfr.wr && (sfr.addr == `CRCCA_ADDR_IN);
   wire wr_flip  = sfr.wr && (sfr.addr == `CRCCA_ADDR_FLIP);
   wire wr_auto  = sfr.wr && (sfr.addr == `CRCCA_ADDR_AUTO);
   wire wr_cnt   = sfr.wr && (sfr.addr == `CRCCA_ADDR_CNT);
   wire init_hit = wr_ctrl && sfr.wdata[`CRCCA_CTRL_INIT_BIT];
   // start on a control write while enabled, idle and with a nonzero sector count
   wire auto_go  = wr_ctrl && auto_en_ff && (state_ff == CRCCA_IDLE) && (sec_cnt_ff != 6'h00);
   wire flash_hit = (state_ff == CRCCA_RUN) && flash_ack;
   wire last_byte = flash_hit && (remain_ff == 16'h0001);
   wire [1:0] cur_idx = byte_idx(ctrl_ff.poly16, ctrl_ff.ptr);
   wire [7:0] fold_din = wr_in ? sfr.wdata : flash_rdata;

   // shared fold for CPU bytes and flash bytes
   crcca_engine u_engine (
      .poly16  (ctrl_ff.poly16),
      .crc_in  (result_ff),
      .din     (fold_din),
      .crc_out (fold_out)
   );

   // Read mux; unmapped offsets read as zero
   logic [7:0] rd_mux;
   always_comb begin
      if (sfr.addr == `CRCCA_ADDR_CTRL) begin
         // upper bits and init bit read zero
         rd_mux = {3'b000, ctrl_ff.poly16, 1'b0, ctrl_ff.init_ones, ctrl_ff.ptr};
      end else if (sfr.addr == `CRCCA_ADDR_DATA) begin
         rd_mux = pick_byte(result_ff, cur_idx);
      end else if (sfr.addr == `CRCCA_ADDR_FLIP) begin
         rd_mux = flip_ff;
      end else if (sfr.addr == `CRCCA_ADDR_AUTO) begin
         // Done bit is the inverse of busy; the CPU is held while busy
         rd_mux = {auto_en_ff, state_ff == CRCCA_IDLE, start_sec_ff};
      end else if (sfr.addr == `CRCCA_ADDR_CNT) begin
         rd_mux = {2'b00, sec_cnt_ff};
      end else begin
         rd_mux = 8'h00;
      end
   end

   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (wr_ctrl) begin
         nxt_ctrl.poly16    = sfr.wdata[`CRCCA_CTRL_SEL_BIT];
         nxt_ctrl.init_ones = sfr.wdata[`CRCCA_CTRL_VAL_BIT];
         nxt_ctrl.ptr       = sfr.wdata[1:0];
      end else if (wr_data || rd_data) begin
         nxt_ctrl.ptr = ctrl_ff.ptr + 2'h1;
      end
   end

   always_comb begin
      nxt_result = result_ff;
      if (init_hit) begin
         // whole result loaded, 16-bit mode too
         nxt_result = sfr.wdata[`CRCCA_CTRL_VAL_BIT] ? `CRCCA_INIT_ONES : `CRCCA_INIT_ZEROS;
      end else if (wr_data) begin
         nxt_result[8*cur_idx +: 8] = sfr.wdata;
      end else if (wr_in || flash_hit) begin
         nxt_result = fold_out;
      end
   end

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         CRCCA_IDLE: begin
            if (auto_go) begin
               nxt_state = CRCCA_RUN;
            end
         end
         CRCCA_RUN: begin
            if (last_byte) begin
               nxt_state = CRCCA_IDLE;
            end
         end
         default: begin
            nxt_state = CRCCA_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl_ff  <= crcca_ctrl_t'(`CRCCA_CTRL_RESET);
         state_ff <= CRCCA_IDLE;
         result_ff <= `CRCCA_INIT_ZEROS;
      end else begin
         ctrl_ff   <= nxt_ctrl;
         state_ff  <= nxt_state;
         result_ff <= nxt_result;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         sfr_rdata_ff <= 8'h00;
         flip_ff      <= 8'h00;
         auto_en_ff   <= 1'b0;
         start_sec_ff <= 6'h00;
         sec_cnt_ff   <= 6'h00;
      end else begin
         if (sfr.rd) begin
            sfr_rdata_ff <= rd_mux;
         end
         if (wr_flip) begin
            flip_ff <= {<<{sfr.wdata}};
         end
         if (wr_auto) begin
            auto_en_ff   <= sfr.wdata[`CRCCA_AUTO_EN_BIT];
            start_sec_ff <= sfr.wdata[5:0];
         end
         if (wr_cnt) begin
            sec_cnt_ff <= sfr.wdata[5:0];
         end
      end
   end

   // hold rises one cycle after the starting write, so the
   // fetch already in flight then may return an indeterminate byte
   always_ff @(posedge mclk) begin
      if (rst) begin
         cpu_hold_ff   <= 1'b0;
         flash_req_ff  <= 1'b0;
         flash_addr_ff <= 16'h0000;
         remain_ff     <= 16'h0000;
      end else if (auto_go) begin
         cpu_hold_ff   <= 1'b1;
         flash_req_ff  <= 1'b1;
         flash_addr_ff <= 16'({start_sec_ff, 10'h000});
         remain_ff     <= 16'({sec_cnt_ff, 10'h000});
      end else if (flash_hit) begin
         cpu_hold_ff   <= !last_byte;
         flash_req_ff  <= !last_byte;
         flash_addr_ff <= flash_addr_ff + 16'h0001;
         remain_ff     <= remain_ff - 16'h0001;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_ctrl_rd;
      rd_ctrl;
   endsequence
   sequence s_in_zero_on_zero;
      wr_in && !init_hit && result_ff == 32'h00000000 && sfr.wdata == 8'h01;
   endsequence

   AST_UPPER_ZERO: assert property (s_ctrl_rd |=> sfr_rdata_ff[7:5] == 3'b000)
      else $error("control upper bits not zero");
   AST_INIT_ONESHOT: assert property (s_ctrl_rd |=> !sfr_rdata_ff[3])
      else $error("init bit reads back set");
   AST_INIT_LOAD: assert property (init_hit |=> result_ff ==
      ($past(sfr.wdata[2]) ? 32'hFFFFFFFF : 32'h00000000))
      else $error("init did not load result");
   AST_PTR_INC: assert property ((rd_data || wr_data) && !wr_ctrl |=>
      ctrl_ff.ptr == 2'($past(ctrl_ff.ptr) + 2'h1))
      else $error("pointer did not advance");
   AST_RD32: assert property (rd_data && !ctrl_ff.poly16 |=>
      sfr_rdata_ff == $past(result_ff[8*ctrl_ff.ptr +: 8]))
      else $error("wrong byte in 32-bit mode");
   AST_RD16: assert property (rd_data && ctrl_ff.poly16 |=>
      sfr_rdata_ff == ($past(ctrl_ff.ptr[0]) ? $past(result_ff[15:8]) : $past(result_ff[7:0])))
      else $error("wrong byte in 16-bit mode");
   AST_CRC32_ONE: assert property ((s_in_zero_on_zero and (!ctrl_ff.poly16)) |=>
      result_ff == 32'h77073096)
      else $error("32-bit fold wrong");
   AST_CRC16_ONE: assert property ((s_in_zero_on_zero and (ctrl_ff.poly16)) |=>
      result_ff == 32'h00001021)
      else $error("16-bit fold wrong");
   AST_UPPER16_KEPT: assert property (wr_in && ctrl_ff.poly16 |=>
      result_ff[31:16] == $past(result_ff[31:16]))
      else $error("16-bit fold touched upper half");
   AST_AUTO_START: assert property (auto_go |=> cpu_hold_ff && flash_req_ff
      && flash_addr_ff == 16'({$past(start_sec_ff), 10'h000}))
      else $error("automatic CRC did not start");
   AST_RESET_CTRL: assert property (@(posedge mclk) $past(rst) |->
      ctrl_ff == crcca_ctrl_t'(4'h0))
      else $error("control not reset");
endmodule // crcca_top

/* logic/crcca_map.svh */
// Register offsets, field positions, reset values and constants of the CRC control block
`ifndef CRCCA_MAP_SVH
`define CRCCA_MAP_SVH
`define CRCCA_ADDR_DATA    8'h91
`define CRCCA_ADDR_CTRL    8'h92
`define CRCCA_ADDR_IN      8'h93
`define CRCCA_ADDR_FLIP    8'h95
`define CRCCA_ADDR_AUTO    8'h96
`define CRCCA_ADDR_CNT     8'h97
`define CRCCA_CTRL_SEL_BIT 4
`define CRCCA_CTRL_INIT_BIT 3
`define CRCCA_CTRL_VAL_BIT 2
`define CRCCA_AUTO_EN_BIT  7
`define CRCCA_CTRL_RESET   8'h00
`define CRCCA_INIT_ZEROS   32'h00000000
`define CRCCA_INIT_ONES    32'hFFFFFFFF
`define CRCCA_POLY32_REFL  32'hEDB88320
`define CRCCA_POLY16       16'h1021
`define CRCCA_SECTOR_SHIFT 10
`endif

/* logic/crcca_pkg.sv */
// Types shared by the CRC control block
package crcca_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } crcca_sfr_t;

   typedef struct packed {
      logic       poly16;
      logic       init_ones;
      logic [1:0] ptr;
   } crcca_ctrl_t;

   typedef enum logic [0:0] {
      CRCCA_IDLE = 1'b0,
      CRCCA_RUN  = 1'b1
   } crcca_state_t;
endpackage

/* logic/crcca_engine.sv */
// Byte-wide CRC fold, reflected 32-bit or MSB-first 16-bit
`timescale 1ns/1ps
`include "crcca_map.svh"
module crcca_engine (
   input  wire logic        poly16,
   input  wire logic [31:0] crc_in,
   input  wire logic [7:0]  din,
   output logic      [31:0] crc_out
);
   import crcca_pkg::*;

   function automatic logic [31:0] fold(input logic sel16, input logic [31:0] c,
                                        input logic [7:0] d);
      logic [31:0] r;
      logic [15:0] h;
      r = c ^ {24'h000000, d};
      h = c[15:0] ^ {d, 8'h00};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ `CRCCA_POLY32_REFL) : (r >> 1);
         h = h[15] ? ((h << 1) ^ `CRCCA_POLY16) : (h << 1);
      end
      // Upper half is left untouched in 16-bit mode
      fold = sel16 ? {c[31:16], h} : r;
   endfunction

   always_comb begin
      crc_out = fold(poly16, crc_in, din);
   end
endmodule // crcca_engine

/* dv/crcca_flash_model.sv */
// Flash memory model answering the automatic CRC byte requests
`timescale 1ns/1ps
module crcca_flash_model (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        flash_req_ff,
   input  wire logic [15:0] flash_addr_ff,
   output logic      [7:0]  flash_rdata,
   output logic             flash_ack
);
   logic       ph_ff;
   wire  [7:0] fl_byte = flash_addr_ff[7:0] ^ flash_addr_ff[15:8] ^ 8'h5A;
   // Prompt on some addresses, every other cycle on the rest
   always_ff @(posedge mclk) begin
      ph_ff     <= ~ph_ff & ~rst;
      flash_ack <= flash_req_ff & ~flash_ack & ~rst & (flash_addr_ff[3] | ph_ff);
   end
   // Outside the ack the data lines show no stale byte
   assign flash_rdata = flash_ack ? fl_byte : ~fl_byte;
endmodule // crcca_flash_model

/* dv/tb_crcca_top.sv */
// Self-checking bench for the CRC control block
`timescale 1ns/1ps
`include "crcca_map.svh"
module tb_crcca_top;
   import crcca_pkg::*;
   typedef struct {logic [7:0] ctrl; logic [7:0] din; logic [31:0] res;} crcca_row_t;
   logic        mclk = 1'b0;
   logic        rst  = 1'b1;
   crcca_sfr_t  sfr  = '0;
   logic [7:0]  rdata;
   logic [15:0] addr;
   logic        req;
   logic        hold;
   logic        fl_ack;
   logic [7:0]  fl_data;
   logic [31:0] res;
   logic [31:0] exp_crc;
   int          error_cnt  = 0;
   int          num_checks = 0;
   crcca_row_t  rows [6] = '{'{8'h08, 8'h01, 32'h77073096}, '{8'h18, 8'h01, 32'h00001021},
      '{8'h1C, 8'h63, 32'h0000BD35}, '{8'h1C, 8'h8C, 32'h0000B1F4},
      '{8'h1C, 8'h7D, 32'h00004ECA}, '{8'h0C, 8'h63, 32'hF9462090}};

   always #2.5 mclk = ~mclk;

   crcca_top dut (.mclk(mclk), .rst(rst), .sfr(sfr), .sfr_rdata_ff(rdata),
      .flash_req_ff(req), .flash_addr_ff(addr), .flash_rdata(fl_data),
      .flash_ack(fl_ack), .cpu_hold_ff(hold));
   crcca_flash_model fm (.mclk(mclk), .rst(rst), .flash_req_ff(req),
      .flash_addr_ff(addr), .flash_rdata(fl_data), .flash_ack(fl_ack));

   function automatic logic [31:0] fold(input logic p16, input logic [31:0] c,
                                        input logic [7:0] b);
      if (p16) begin
         c[15:0] = c[15:0] ^ {b, 8'h00};
         for (int i = 0; i < 8; i++)
            c[15:0] = c[15] ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
      end else begin
         c[7:0] = c[7:0] ^ b;
         for (int i = 0; i < 8; i++)
            c = c[0] ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
      end
      return c;
   endfunction

   // One register access; a gap cycle follows so strobes never retoggle at once
   task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d);
      @(negedge mclk);
      sfr = '{addr: a, wr: w, rd: ~w, wdata: d};
      @(negedge mclk);
      sfr = '0;
   endtask

   task automatic get_res(output logic [31:0] r);
      for (int k = 0; k < 4; k++) begin
         acc(8'h91, 1'b0, 8'h00);
         r[8*k+:8] = rdata;
      end
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Whole run needs about 2300 cycles
   initial begin
      #200000;
      error_cnt++;
      test_done;
   end

   initial begin
      repeat (5) @(negedge mclk);
      rst = 1'b0;
      acc(8'h92, 1'b0, 8'h00);
      chk("ctrl rst", 32'h0, {24'h0, rdata});
      get_res(res);
      chk("res rst", 32'h0, res);
      foreach (rows[i]) begin
         acc(8'h92, 1'b1, rows[i].ctrl);
         acc(8'h93, 1'b1, rows[i].din);
         get_res(res);
         chk("res", rows[i].ctrl[4] ? {2{rows[i].res[15:0]}} : rows[i].res, res);
         acc(8'h92, 1'b0, 8'h00);
         chk("ctrl", {24'h0, rows[i].ctrl & 8'h14}, {24'h0, rdata});
      end
      acc(8'h92, 1'b1, 8'hFF);
      acc(8'h92, 1'b0, 8'h00);
      chk("ctrl ff", 32'h17, {24'h0, rdata});
      acc(8'h91, 1'b0, 8'h00);
      chk("ptr3", 32'hFF, {24'h0, rdata});
      acc(8'h92, 1'b0, 8'h00);
      chk("ptr wrap", 32'h14, {24'h0, rdata});
      acc(8'h92, 1'b1, 8'h08);
      for (int k = 0; k < 4; k++)
         acc(8'h91, 1'b1, 8'(8'h11 * (k + 1)));
      get_res(res);
      chk("dat wr", 32'h44332211, res);
      for (int m = 0; m < 2; m++) begin
         acc(8'h92, 1'b1, m ? 8'h1C : 8'h0C);
         for (int j = 0; j < 3; j++)
            acc(8'h93, 1'b1, 8'(8'hAA + 8'h11 * j));
         get_res(res);
         chk("stream", m ? 32'h6CF66CF6 : 32'h41B207B3, res);
      end
      acc(8'h96, 1'b1, 8'h82);
      acc(8'h97, 1'b1, 8'h01);
      acc(8'h92, 1'b1, 8'h0C);
      chk("start", 32'h00030800, {14'h0, req, hold, addr});
      acc(8'h95, 1'b1, 8'h5A);
      exp_crc = 32'hFFFFFFFF;
      for (int a = 16'h0800; a < 16'h0C00; a++)
         exp_crc = fold(1'b0, exp_crc, 8'(a ^ (a >> 8)) ^ 8'h5A);
      for (int n = 0; n < 4000 && hold !== 1'b0; n++)
         @(negedge mclk);
      chk("hold end", 32'h0, {30'h0, req, hold});
      acc(8'h96, 1'b0, 8'h00);
      chk("auto reg", 32'hC2, {24'h0, rdata});
      acc(8'h96, 1'b1, 8'h02);
      get_res(res);
      chk("auto crc", exp_crc, res);
      acc(8'h96, 1'b1, 8'h82);
      acc(8'h97, 1'b1, 8'h00);
      acc(8'h92, 1'b1, 8'h00);
      chk("cnt0", 32'h0, {31'h0, hold});
      test_done;
   end
endmodule // tb_crcca_top
